// ---- include/sfs_pkg.sv ----
// package for the serial flash status register block
package sfs_pkg;
    localparam int STAT_W = 8;
    localparam int BUSY_POS = 0;
    localparam int WEL_POS = 1;
    localparam int BP_LO = 2;
    localparam int BP_HI = 4;
    localparam int EFAULT_POS = 5;
    localparam int PFAULT_POS = 6;
    localparam int LOCK_POS = 7;
    localparam int CFG_QUAD_POS = 1;
    localparam int CFG_PERSIST_POS = 3;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] STAT_WRITABLE = 8'h9c;
    localparam logic [7:0] CFG_LOCKED = 8'h2e;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_REG_WRITE = 8'h01;
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_STATUS_CLEAR = 8'h30;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE = 8'h32;
    localparam logic [7:0] OP_WIPE_4K = 8'h20;
    localparam logic [7:0] OP_WIPE_8K = 8'h40;
    localparam logic [7:0] OP_WIPE_64K = 8'hd8;
    localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
    localparam logic [4:0] BITS_OPCODE = 5'd8;
    localparam logic [4:0] BITS_ONE_BYTE = 5'd16;
    localparam logic [4:0] BITS_TWO_BYTE = 5'd24;
    localparam int SCK_MAX_MHZ = 104;
    localparam int REGWR_TIME_NS = 200;
    localparam int CLK_NS = 8;
    localparam int REGWR_CYCLES = REGWR_TIME_NS / CLK_NS;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp;
    } sfs_pins_t;

    typedef struct packed {
        logic done;
        logic fault;
        logic is_erase;
    } sfs_op_end_t;
endpackage

// ---- hw/sfs_status.sv ----
// status register, read-status command and register protection of a serial flash
// What this block does
// - read status accepted at any moment
// - status byte repeats until chip select rises
// - read status works only while sck stays well below clk/4
// - bit 0 busy, internal, read-only
// - latch gates write, program, erase commands
// - latch set/clear commands, cleared on completion
// - register write data never sets the latch; the write clears it on completion
// - protect field blocks program and erase
// - protect bits loaded by register write
// - bulk erase only with zero protect bits
// - protect bits reset to zero
// - erase fault sticky until status clear
// - program fault sticky until status clear
// - protected attempts set no fault flag
// - lock bit plus low pin locks registers
// - lock bit zero gives no protection
// - write ends at 8 or 16 data bits
// - lock leaves only when pin goes high
// - four-lane mode disables hardware lock
`timescale 1ns/1ps
module sfs_status #(
    parameter int REGWR_COUNT = sfs_pkg::REGWR_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire sfs_pkg::sfs_pins_t pins,
    input wire logic array_busy,
    input wire sfs_pkg::sfs_op_end_t op_end,
    output logic so,
    output logic so_oe,
    output logic [7:0] status_byte,
    output logic [7:0] config_byte,
    output logic hw_locked,
    output logic program_start,
    output logic erase_start,
    output logic [7:0] array_opcode
);
    typedef enum {SFS_OPCODE, SFS_DATA, SFS_READOUT, SFS_IGNORE} sfs_state_t;

    sfs_pkg::sfs_pins_t sync1, sync2;
    logic sck_prev;
    logic [7:0] status;
    logic [7:0] cfg;
    sfs_state_t state;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [7:0] opcode;
    logic [7:0] shift_out;
    logic out_bit;
    logic regwr_busy;
    logic [15:0] regwr_cnt;

    logic [7:0] next_status;
    logic [7:0] next_cfg;
    sfs_state_t next_state;
    logic [4:0] next_bit_cnt;
    logic [15:0] next_shift_in;
    logic [7:0] next_opcode;
    logic [7:0] next_shift_out;
    logic next_out_bit;
    logic next_regwr_busy;
    logic [15:0] next_regwr_cnt;
    logic next_program_start;
    logic next_erase_start;
    logic [7:0] next_array_opcode;

    logic sck_rise, sck_fall, cs_low;
    logic [7:0] rx_byte;
    logic lock_active, protected_any;

    function automatic logic is_array_op(input logic [7:0] op);
        return op == sfs_pkg::OP_PAGE_WRITE || op == sfs_pkg::OP_QUAD_PAGE
            || op == sfs_pkg::OP_WIPE_4K || op == sfs_pkg::OP_WIPE_8K
            || op == sfs_pkg::OP_WIPE_64K || op == sfs_pkg::OP_BULK_ERASE;
    endfunction

    function automatic logic is_erase_op(input logic [7:0] op);
        return op != sfs_pkg::OP_PAGE_WRITE && op != sfs_pkg::OP_QUAD_PAGE;
    endfunction

    // oversampled link clock: edges are only found while sck stays well below clk/4
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // idle pin levels, so no false frame start follows reset
            sync1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp: 1'b1};
            sync2 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp: 1'b1};
            sck_prev <= 1'b0;
        end
        else
        begin
            sync1 <= pins;
            sync2 <= sync1;
            sck_prev <= sync2.sck;
        end
    end

    assign cs_low = !sync2.cs_n;
    assign sck_rise = cs_low && sync2.sck && !sck_prev;
    assign sck_fall = cs_low && !sync2.sck && sck_prev;
    assign rx_byte = {shift_in[6:0], sync2.si};

    // lock needs the bit set, the pin low and four-lane mode off
    assign lock_active = status[sfs_pkg::LOCK_POS] && !sync2.wp
        && !cfg[sfs_pkg::CFG_QUAD_POS];
    assign protected_any = |status[sfs_pkg::BP_HI:sfs_pkg::BP_LO];

    always_comb
    begin
        next_status = status;
        next_cfg = cfg;
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_opcode = opcode;
        next_shift_out = shift_out;
        next_out_bit = out_bit;
        next_regwr_busy = regwr_busy;
        next_regwr_cnt = regwr_cnt;
        next_program_start = 1'b0;
        next_erase_start = 1'b0;
        next_array_opcode = array_opcode;

        if (regwr_busy)
        begin
            if (regwr_cnt == 16'd0)
            begin
                next_regwr_busy = 1'b0;
                next_status[sfs_pkg::WEL_POS] = 1'b0;
            end
            else
                next_regwr_cnt = regwr_cnt - 16'd1;
        end

        if (op_end.done)
        begin
            next_status[sfs_pkg::WEL_POS] = 1'b0;
        end

        if (sync2.cs_n)
        begin
            if (state == SFS_DATA && opcode == sfs_pkg::OP_REG_WRITE
                && (bit_cnt == sfs_pkg::BITS_ONE_BYTE || bit_cnt == sfs_pkg::BITS_TWO_BYTE)
                && status[sfs_pkg::WEL_POS] && !lock_active && !regwr_busy)
            begin
                // writable mask keeps latch, busy and faults untouched
                next_status = (next_status & ~sfs_pkg::STAT_WRITABLE)
                    | (bit_cnt == sfs_pkg::BITS_TWO_BYTE ? shift_in[15:8] : shift_in[7:0])
                    & sfs_pkg::STAT_WRITABLE;
                if (bit_cnt == sfs_pkg::BITS_TWO_BYTE)
                    next_cfg = shift_in[7:0];
                next_regwr_busy = 1'b1;
                next_regwr_cnt = REGWR_COUNT[15:0];
            end
            next_state = SFS_OPCODE;
            next_bit_cnt = 5'd0;
        end
        else if (sck_rise && state != SFS_READOUT)
        begin
            next_shift_in = {shift_in[14:0], sync2.si};
            next_bit_cnt = bit_cnt + 5'd1;
            if (state == SFS_OPCODE && bit_cnt == sfs_pkg::BITS_OPCODE - 5'd1)
            begin
                next_opcode = rx_byte;
                next_state = SFS_IGNORE;
                case (rx_byte)
                    sfs_pkg::OP_READ_STATUS:
                    begin
                        next_state = SFS_READOUT;
                        next_shift_out = status_byte;
                    end
                    sfs_pkg::OP_REG_WRITE:
                        next_state = SFS_DATA;
                    sfs_pkg::OP_LATCH_SET:
                        next_status[sfs_pkg::WEL_POS] = 1'b1;
                    sfs_pkg::OP_LATCH_CLEAR:
                        next_status[sfs_pkg::WEL_POS] = 1'b0;
                    sfs_pkg::OP_STATUS_CLEAR:
                    begin
                        next_status[sfs_pkg::EFAULT_POS] = 1'b0;
                        next_status[sfs_pkg::PFAULT_POS] = 1'b0;
                    end
                    default:
                    begin
                        // region decode is elsewhere; any protect bit refuses here
                        if (is_array_op(rx_byte) && status[sfs_pkg::WEL_POS]
                            && !protected_any && !array_busy)
                        begin
                            next_program_start = !is_erase_op(rx_byte);
                            next_erase_start = is_erase_op(rx_byte);
                            next_array_opcode = rx_byte;
                        end
                    end
                endcase
            end
            else if (state == SFS_DATA && bit_cnt == sfs_pkg::BITS_TWO_BYTE)
                next_state = SFS_IGNORE;
        end
        else if (sck_fall && state == SFS_READOUT)
        begin
            // status sampled fresh per byte so busy tracks live
            next_out_bit = shift_out[7];
            next_bit_cnt = bit_cnt + 5'd1;
            if (bit_cnt == sfs_pkg::BITS_ONE_BYTE - 5'd1)
            begin
                next_shift_out = status_byte;
                next_bit_cnt = sfs_pkg::BITS_OPCODE;
            end
            else
                next_shift_out = {shift_out[6:0], 1'b0};
        end

        // a fault landing with a clear strobe survives: the set wins
        if (op_end.done && op_end.fault)
        begin
            if (op_end.is_erase)
                next_status[sfs_pkg::EFAULT_POS] = 1'b1;
            else
                next_status[sfs_pkg::PFAULT_POS] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            status <= sfs_pkg::STAT_RESET;
            cfg <= sfs_pkg::CFG_RESET;
            state <= SFS_OPCODE;
            bit_cnt <= 5'd0;
            shift_in <= 16'h0000;
            opcode <= 8'h00;
            shift_out <= 8'h00;
            out_bit <= 1'b0;
            regwr_busy <= 1'b0;
            regwr_cnt <= 16'h0000;
            program_start <= 1'b0;
            erase_start <= 1'b0;
            array_opcode <= 8'h00;
        end
        else
        begin
            status <= next_status;
            cfg <= next_cfg;
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            opcode <= next_opcode;
            shift_out <= next_shift_out;
            out_bit <= next_out_bit;
            regwr_busy <= next_regwr_busy;
            regwr_cnt <= next_regwr_cnt;
            program_start <= next_program_start;
            erase_start <= next_erase_start;
            array_opcode <= next_array_opcode;
        end
    end

    always_comb
    begin
        status_byte = status;
        status_byte[sfs_pkg::BUSY_POS] = regwr_busy || array_busy;
    end
    assign config_byte = cfg;
    assign hw_locked = lock_active;
    assign so = out_bit;
    assign so_oe = state == SFS_READOUT;

    // a write frame closing with chip select high
    sequence wr_end_s;
        sync2.cs_n && state == SFS_DATA && opcode == sfs_pkg::OP_REG_WRITE;
    endsequence

    latch_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        sck_rise && state == SFS_OPCODE && bit_cnt == sfs_pkg::BITS_OPCODE - 5'd1
        && rx_byte == sfs_pkg::OP_LATCH_SET |=> status[sfs_pkg::WEL_POS]) else $error("latch not set");
    lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        lock_active && !regwr_busy |=> status[sfs_pkg::LOCK_POS] == $past(status[sfs_pkg::LOCK_POS])
        && status[sfs_pkg::BP_HI:sfs_pkg::BP_LO] == $past(status[sfs_pkg::BP_HI:sfs_pkg::BP_LO]))
        else $error("locked bits changed");
    bulk_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
        erase_start && array_opcode == sfs_pkg::OP_BULK_ERASE
        |-> $past(status[sfs_pkg::BP_HI:sfs_pkg::BP_LO]) == 3'h0) else $error("bulk erase while protected");
    // busy must stand for the first four cycles of the self-timed write
    busy_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(regwr_busy) |-> status_byte[sfs_pkg::BUSY_POS] [*4]) else $error("busy not shown");
    fault_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        status[sfs_pkg::PFAULT_POS] && !(sck_rise && rx_byte == sfs_pkg::OP_STATUS_CLEAR)
        |=> status[sfs_pkg::PFAULT_POS]) else $error("program fault lost");
    efault_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        status[sfs_pkg::EFAULT_POS] && !(sck_rise && rx_byte == sfs_pkg::OP_STATUS_CLEAR)
        |=> status[sfs_pkg::EFAULT_POS]) else $error("erase fault lost");
    gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(regwr_busy) |-> $past(status[sfs_pkg::WEL_POS])) else $error("write without latch");
    wr_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_end_s ##0 !status[sfs_pkg::WEL_POS] |=> !$rose(regwr_busy)) else $error("refused write ran");
    // four-lane mode turns the pin into data, so a low pin must not lock
    quad_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_end_s ##0 (cfg[sfs_pkg::CFG_QUAD_POS] && status[sfs_pkg::LOCK_POS] && !sync2.wp
        && status[sfs_pkg::WEL_POS] && !regwr_busy
        && (bit_cnt == sfs_pkg::BITS_ONE_BYTE || bit_cnt == sfs_pkg::BITS_TWO_BYTE))
        |=> $rose(regwr_busy)) else $error("four-lane write refused");
endmodule

// ---- testbench/sfs_host_model.sv ----
// host spi controller model driving the flash pins
`timescale 1ns/1ps
module sfs_host_model (
    input wire logic clk,
    input wire logic so,
    input wire logic wp,
    output sfs_pkg::sfs_pins_t pins,
    output logic [7:0] rd_byte,
    output logic rd_valid
);
    logic cs_n = 1'h1;
    logic sck = 1'h0;
    logic si = 1'h0;
    assign pins = '{cs_n: cs_n, sck: sck, si: si, wp: wp};
    initial rd_valid = 1'h0;
    initial rd_byte = 8'h00;
    // sck stands low between frames; half period 5 clk keeps far below the rate ceiling
    task automatic xfer(input logic [7:0] b, input logic rd);
        for (int i = 7; i >= 0; i--)
        begin
            si = b[i];
            repeat (5) @(negedge clk);
            sck = 1'h1;
            rd_byte[i] = so;
            repeat (5) @(negedge clk);
            sck = 1'h0;
        end
        rd_valid = rd;
        @(negedge clk) rd_valid = 1'h0;
    endtask
    task automatic start();
        @(negedge clk) cs_n = 1'h0;
        repeat (4) @(negedge clk);
    endtask
    // the host alone ends a read by raising chip select
    task automatic stop();
        repeat (4) @(negedge clk);
        cs_n = 1'h1;
        si = ~si;
        repeat (12) @(negedge clk);
    endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the status register block
`timescale 1ns/1ps
module testbench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic wp = 1'h1;
    logic array_busy = 1'h0;
    sfs_pkg::sfs_op_end_t op_end = '0;
    sfs_pkg::sfs_pins_t pins;
    logic so, so_oe, hw_locked, program_start, erase_start, rd_valid;
    logic [7:0] status_byte, config_byte, array_opcode, rd_byte, d;
    logic [7:0] st = 8'h00;
    logic [7:0] cf = 8'h00;
    logic [7:0] exp_rd[$];
    logic [8:0] exp_op[$];
    logic [7:0] ops [6] = '{sfs_pkg::OP_PAGE_WRITE, sfs_pkg::OP_QUAD_PAGE, sfs_pkg::OP_WIPE_4K,
        sfs_pkg::OP_WIPE_8K, sfs_pkg::OP_WIPE_64K, sfs_pkg::OP_BULK_ERASE};
    int fails = 0;
    int checks = 0;
    initial forever #4 clk = ~clk;
    sfs_status #(.REGWR_COUNT(4)) sfs_status_i (.clk(clk), .rst_n(rst_n), .pins(pins),
        .array_busy(array_busy), .op_end(op_end), .so(so), .so_oe(so_oe), .status_byte(status_byte),
        .config_byte(config_byte), .hw_locked(hw_locked), .program_start(program_start),
        .erase_start(erase_start), .array_opcode(array_opcode));
    sfs_host_model sfs_host_model_i (.clk(clk), .so(so), .wp(wp), .pins(pins), .rd_byte(rd_byte),
        .rd_valid(rd_valid));
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // valid spans negedge to negedge, so exactly one rising edge sees it
    always @(posedge clk)
    begin
        if (rd_valid === 1'h1)
        begin
            chk({1'h0, rd_byte}, exp_rd.size() ? {1'h0, exp_rd.pop_front()} : 9'h1ff, "status read");
            chk({8'h00, so_oe}, 9'h001, "drive enable");
        end
    end
    // opcode 8'hff never starts an array op, so an unexpected start always fails
    always @(negedge clk)
    begin
        if (program_start === 1'h1 || erase_start === 1'h1)
            chk({erase_start, array_opcode}, exp_op.size() ? exp_op.pop_front() : 9'h1ff, "array start");
    end
    task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] dat);
        sfs_host_model_i.start();
        sfs_host_model_i.xfer(op, 1'h0);
        for (int i = 0; i < n; i++)
            sfs_host_model_i.xfer(dat[23 - 8 * i -: 8], 1'h0);
        sfs_host_model_i.stop();
    endtask
    task automatic rd_status(input int n);
        sfs_host_model_i.start();
        sfs_host_model_i.xfer(sfs_pkg::OP_READ_STATUS, 1'h0);
        for (int i = 0; i < n; i++)
        begin
            exp_rd.push_back(st);
            sfs_host_model_i.xfer(8'h00, 1'h1);
        end
        sfs_host_model_i.stop();
        chk({8'h00, so_oe}, 9'h000, "drive released");
    endtask
    task automatic wait_idle();
        int k;
        for (k = 0; k < 300 && status_byte[0] !== 1'h0; k++)
            @(negedge clk);
        if (k == 300)
        begin
            fails++;
            $display("MISMATCH %0t busy never cleared", $time);
            finish_test();
        end
    endtask
    task automatic reg_wr(input int n, input logic [15:0] v, input logic ok);
        cmd(sfs_pkg::OP_LATCH_SET, 0, 24'h0);
        st[1] = 1'h1;
        cmd(sfs_pkg::OP_REG_WRITE, n, {v, 8'h00});
        if (ok)
        begin
            st = (v[15:8] & sfs_pkg::STAT_WRITABLE) | (st & ~sfs_pkg::STAT_WRITABLE);
            st[1] = 1'h0;
            if (n == 2)
                cf = v[7:0];
            wait_idle();
        end
        rd_status(2);
        chk({1'h0, config_byte}, {1'h0, cf}, "config byte");
        if (!ok)
        begin
            cmd(sfs_pkg::OP_LATCH_CLEAR, 0, 24'h0);
            st[1] = 1'h0;
            rd_status(1);
        end
    endtask
    task automatic arr_op(input logic [7:0] op, input logic ers, input int n, input logic ok);
        logic flt;
        flt = 1'($urandom);
        cmd(sfs_pkg::OP_LATCH_SET, 0, 24'h0);
        st[1] = 1'h1;
        if (ok)
            exp_op.push_back({ers, op});
        cmd(op, n, 24'h0);
        if (ok)
        begin
            array_busy = 1'h1;
            st[0] = 1'h1;
            rd_status(1);
            array_busy = 1'h0;
            st[0] = 1'h0;
            op_end = '{done: 1'h1, fault: flt, is_erase: ers};
            @(negedge clk) op_end = '0;
            st[1] = 1'h0;
            st[ers ? 5 : 6] |= flt;
        end
        rd_status(1);
        cmd(sfs_pkg::OP_LATCH_CLEAR, 0, 24'h0);
        st[1] = 1'h0;
    endtask
    initial
    begin
        repeat (60000) @(negedge clk);
        fails++;
        $display("MISMATCH %0t run did not end", $time);
        finish_test();
    end
    initial
    begin
        void'($urandom(32'h88e6));
        repeat (5) @(negedge clk);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
        rd_status(2);
        cmd(sfs_pkg::OP_PAGE_WRITE, 3, 24'h0);
        cmd(sfs_pkg::OP_REG_WRITE, 1, 24'hff0000);
        rd_status(1);
        for (int i = 0; i < 6; i++)
            arr_op(ops[i], i >= 2, i == 5 ? 0 : 3, 1'h1);
        d = 8'($urandom);
        reg_wr(1, {d, 8'h00}, 1'h1);
        cmd(sfs_pkg::OP_STATUS_CLEAR, 0, 24'h0);
        st[6:5] = 2'h0;
        reg_wr(1, {8'h04, 8'h00}, 1'h1);
        arr_op(sfs_pkg::OP_BULK_ERASE, 1'h1, 0, 1'h0);
        reg_wr(1, {8'h9c, 8'h00}, 1'h1);
        for (int i = 0; i < 6; i++)
            arr_op(ops[i], i >= 2, i == 5 ? 0 : 3, 1'h0);
        wp = 1'h0;
        repeat (4) @(negedge clk);
        chk({8'h00, hw_locked}, 9'h001, "lock entry");
        reg_wr(1, {8'h00, 8'h00}, 1'h0);
        wp = 1'h1;
        repeat (4) @(negedge clk);
        chk({8'h00, hw_locked}, 9'h000, "lock exit");
        reg_wr(1, {8'h1c, 8'h00}, 1'h1);
        wp = 1'h0;
        repeat (4) @(negedge clk);
        chk({8'h00, hw_locked}, 9'h000, "no lock bit");
        reg_wr(1, {8'h00, 8'h00}, 1'h1);
        reg_wr(2, {8'h80, 8'h02}, 1'h1);
        chk({8'h00, hw_locked}, 9'h000, "four lane");
        reg_wr(2, {8'h00, 8'h00}, 1'h1);
        wp = 1'h1;
        reg_wr(3, {8'h9c, 8'h00}, 1'h0);
        chk(9'(exp_op.size() + exp_rd.size()), 9'h000, "missing result");
        finish_test();
    end
endmodule
